// ---- hdl/tcc_pkg.sv ----
package tcc_pkg;

  // Register addresses on the plain register port.
  localparam logic [15:0] TCC_ADDR_START = 16'hf030;
  localparam logic [15:0] TCC_ADDR_CONTROL = 16'hf040;
  localparam logic [15:0] TCC_ADDR_MODE = 16'hf041;
  localparam logic [15:0] TCC_ADDR_IO_CTRL = 16'hf042;
  localparam logic [15:0] TCC_ADDR_IRQ_ENABLE = 16'hf044;
  localparam logic [15:0] TCC_ADDR_FLAGS = 16'hf045;
  localparam logic [15:0] TCC_ADDR_COUNTER = 16'hf046;
  localparam logic [15:0] TCC_ADDR_GRA = 16'hf048;

  // Field positions.
  localparam int TCC_RUN_BIT = 1;
  localparam int TCC_FLAG_A_BIT = 0;
  localparam int TCC_IRQ_A_BIT = 0;
  localparam int TCC_CAPTURE_BIT = 0;

  // Field encodings.
  localparam logic [1:0] TCC_CLR_NONE = 2'h0;
  localparam logic [1:0] TCC_CLR_MATCH_A = 2'h1;
  localparam logic [1:0] TCC_EDGE_RISE = 2'h0;
  localparam logic [1:0] TCC_EDGE_FALL = 2'h1;
  localparam logic [1:0] TCC_MODE_NORMAL = 2'h0;

  // Values after reset.
  localparam logic [15:0] TCC_GRA_RESET = 16'hffff;
  localparam logic [15:0] TCC_COUNTER_RESET = 16'h0000;
  localparam logic [7:0] TCC_BYTE_RESET = 8'h00;

  // Width of the free divider.
  localparam int TCC_DIV_WIDTH = 10;

  // Channel control register layout.
  typedef struct packed {
    logic reserved;
    logic [1:0] clear_sel;
    logic [1:0] edge_sel;
    logic [2:0] prescaler_sel;
  } tcc_control_type;

  // Software register port request.
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } tcc_bus_req_type;

endpackage

// ---- hdl/tcc_channel.sv ----
// Overview of operation
// - Clear select 01 clears counter on match A.
// - Edge select 00 counts rising count-clock edges.
// - Prescaler select 110 divides system clock by 256.
// - Mode field 00 means plain normal counting.
// - Interrupt request equals enable AND flag A.
// - Compare mode: counter equals register A sets flag.
// - Capture mode: capture copies counter, sets flag.
// - Flag clears by writing 0 after reading 1.
// - Register A resets to all ones.
// - Register A is 16-bit read/write compare/capture.
// - Counter counts only while run bit is 1.
// - Counter is 16 bits, prescaled internal clock.
`timescale 1ns/1ns
`default_nettype none

module tcc_channel
#(
  parameter int DIV_WIDTH = tcc_pkg::TCC_DIV_WIDTH
)
(
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic reset_n,
  // Register port.
  input wire tcc_pkg::tcc_bus_req_type bus_req,
  output logic [15:0] rd_data,
  // Capture input pin.
  input wire logic capture_in,
  // Compare/capture A interrupt request.
  output logic compare_a_irq_request
);
  import tcc_pkg::*;

  // Refuse a divider too short for the divide-by-1024 tap; a narrower one
  // would leave the upper taps without a source bit.
  if (DIV_WIDTH < 10)
  begin : g_bad_width
    $error("DIV_WIDTH must be at least 10");
  end

  // Reset release synchroniser. Assertion acts at once; release waits two
  // edges, so no register leaves reset on a marginal clock edge.
  logic rst_meta_n;
  logic rst_n;

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta_n <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_n <= 1'b1;
      rst_n <= rst_meta_n;
    end
  end

  // State.
  tcc_control_type control;
  logic [1:0] op_mode;
  logic capture_mode;
  logic compare_a_irq_enable;
  logic compare_a_flag;
  logic flag_read_armed;
  logic channel_run;
  logic [15:0] channel_counter;
  logic [15:0] general_register_a;
  logic [DIV_WIDTH-1:0] div_cnt;
  logic count_clk_prev;
  logic [2:0] cap_sync;
  logic cap_level;
  logic tap_settle;

  // Next values.
  tcc_control_type next_control;
  logic [1:0] next_op_mode;
  logic next_capture_mode;
  logic next_compare_a_irq_enable;
  logic next_compare_a_flag;
  logic next_flag_read_armed;
  logic next_channel_run;
  logic [15:0] next_channel_counter;
  logic [15:0] next_general_register_a;
  logic [DIV_WIDTH-1:0] next_div_cnt;
  logic next_count_clk_prev;
  logic [2:0] next_cap_sync;
  logic next_cap_level;
  logic next_tap_settle;
  logic [15:0] next_rd_data;
  logic next_irq;

  // Helper terms.
  logic count_clk;
  logic count_tick;
  logic match_a;
  logic capture_event;
  logic flag_write;

  // Selects the divided clock that feeds the counter. The taps follow the
  // select encoding, not bit order, and the divider runs free from reset,
  // so the first tick after starting falls anywhere within one period.
  always_comb
  begin
    unique case (control.prescaler_sel)
      3'h0: count_clk = div_cnt[0];
      3'h1: count_clk = div_cnt[1];
      3'h2: count_clk = div_cnt[3];
      3'h3: count_clk = div_cnt[5];
      3'h4: count_clk = div_cnt[2];
      3'h5: count_clk = div_cnt[4];
      3'h6: count_clk = div_cnt[7];
      3'h7: count_clk = div_cnt[9];
    endcase
  end

  // Edge detection on the divided clock and on the capture pin.
  always_comb
  begin
    unique case (control.edge_sel)
      TCC_EDGE_RISE: count_tick = count_clk & ~count_clk_prev;
      TCC_EDGE_FALL: count_tick = ~count_clk & count_clk_prev;
      default: count_tick = count_clk ^ count_clk_prev;
    endcase
    // A new tap or edge choice compares against the old tap's last level,
    // which can look like an edge; the cycle after a control write is
    // ignored, at the cost of a real edge that falls exactly there.
    count_tick = count_tick & ~tap_settle;
    // A capture counts once the second and third stages agree on a rise.
    // The level is tracked in every mode, so a pin already high does not
    // capture the moment capture mode is switched on.
    capture_event = capture_mode & (cap_sync[1] == cap_sync[2])
      & cap_sync[2] & ~cap_level;
    // A match is seen only on a tick, so a stopped counter sets no flag.
    match_a = ~capture_mode & channel_run & count_tick
      & (channel_counter == general_register_a);
    flag_write = bus_req.wr & (bus_req.addr == TCC_ADDR_FLAGS);
  end

  // Prescaler, synchroniser and counter next values.
  always_comb
  begin
    next_div_cnt = div_cnt + 1'b1;
    next_count_clk_prev = count_clk;
    next_tap_settle = bus_req.wr && bus_req.addr == TCC_ADDR_CONTROL;
    next_cap_sync = {cap_sync[1:0], capture_in};
    next_cap_level = cap_level;
    if (cap_sync[1] == cap_sync[2])
    begin
      next_cap_level = cap_sync[2];
    end
    next_channel_counter = channel_counter;
    // Every mode value counts plainly; only normal mode is defined.
    if (channel_run && count_tick)
    begin
      if (match_a && control.clear_sel == TCC_CLR_MATCH_A)
      begin
        next_channel_counter = TCC_COUNTER_RESET;
      end
      else
      begin
        next_channel_counter = channel_counter + 16'h0001;
      end
    end
    // A software write to the counter wins over a count in the same cycle.
    if (bus_req.wr && bus_req.addr == TCC_ADDR_COUNTER)
    begin
      next_channel_counter = bus_req.wdata;
    end
  end

  // Software registers, register A and flag next values. The spare control
  // bit always stores zero, so it reads back as zero.
  always_comb
  begin
    next_control = control;
    next_op_mode = op_mode;
    next_capture_mode = capture_mode;
    next_compare_a_irq_enable = compare_a_irq_enable;
    next_channel_run = channel_run;
    next_general_register_a = general_register_a;
    if (bus_req.wr)
    begin
      unique case (bus_req.addr)
        TCC_ADDR_START: next_channel_run = bus_req.wdata[TCC_RUN_BIT];
        TCC_ADDR_CONTROL:
        begin
          next_control = tcc_control_type'(bus_req.wdata[7:0]);
          next_control.reserved = 1'b0;
        end
        TCC_ADDR_MODE: next_op_mode = bus_req.wdata[1:0];
        TCC_ADDR_IO_CTRL: next_capture_mode = bus_req.wdata[TCC_CAPTURE_BIT];
        TCC_ADDR_IRQ_ENABLE:
          next_compare_a_irq_enable = bus_req.wdata[TCC_IRQ_A_BIT];
        TCC_ADDR_GRA: next_general_register_a = bus_req.wdata;
        default: ;
      endcase
    end
    // A capture overrides a same-cycle software write to register A.
    if (capture_event)
    begin
      next_general_register_a = channel_counter;
    end
    // Arm the clear on reading the flag as one; a flag write disarms unless that read comes in the same cycle.
    // The two steps keep a stray zero write from dropping an event that
    // software has not yet seen.
    next_flag_read_armed = flag_read_armed;
    if (bus_req.rd && bus_req.addr == TCC_ADDR_FLAGS && compare_a_flag)
    begin
      next_flag_read_armed = 1'b1;
    end
    else if (flag_write)
    begin
      next_flag_read_armed = 1'b0;
    end
    next_compare_a_flag = compare_a_flag;
    if (flag_write && flag_read_armed && !bus_req.wdata[TCC_FLAG_A_BIT])
    begin
      next_compare_a_flag = 1'b0;
    end
    // Set wins over a same-cycle clear, so no event is lost.
    if (match_a || capture_event)
    begin
      next_compare_a_flag = 1'b1;
    end
    // The request follows the next values, so it rises with the flag.
    next_irq = next_compare_a_irq_enable & next_compare_a_flag;
  end

  // Read data, valid in the cycle after the read strobe.
  // Idle and unmapped cycles return zero, so read data can be ORed.
  always_comb
  begin
    next_rd_data = 16'h0000;
    if (bus_req.rd)
    begin
      unique case (bus_req.addr)
        TCC_ADDR_START: next_rd_data[TCC_RUN_BIT] = channel_run;
        TCC_ADDR_CONTROL: next_rd_data[7:0] = control;
        TCC_ADDR_MODE: next_rd_data[1:0] = op_mode;
        TCC_ADDR_IO_CTRL: next_rd_data[TCC_CAPTURE_BIT] = capture_mode;
        TCC_ADDR_IRQ_ENABLE:
          next_rd_data[TCC_IRQ_A_BIT] = compare_a_irq_enable;
        TCC_ADDR_FLAGS: next_rd_data[TCC_FLAG_A_BIT] = compare_a_flag;
        TCC_ADDR_COUNTER: next_rd_data = channel_counter;
        TCC_ADDR_GRA: next_rd_data = general_register_a;
        default: next_rd_data = 16'h0000;
      endcase
    end
  end

  // Registers every state element but the reset synchroniser. Every output leaves a flip-flop, so the
  // read data and the request line never glitch.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      control <= tcc_control_type'(TCC_BYTE_RESET);
      op_mode <= TCC_MODE_NORMAL;
      capture_mode <= 1'b0;
      compare_a_irq_enable <= 1'b0;
      compare_a_flag <= 1'b0;
      flag_read_armed <= 1'b0;
      channel_run <= 1'b0;
      channel_counter <= TCC_COUNTER_RESET;
      general_register_a <= TCC_GRA_RESET;
      div_cnt <= '0;
      count_clk_prev <= 1'b0;
      cap_sync <= 3'h0;
      cap_level <= 1'b0;
      tap_settle <= 1'b0;
      rd_data <= 16'h0000;
      compare_a_irq_request <= 1'b0;
    end
    else
    begin
      control <= next_control;
      op_mode <= next_op_mode;
      capture_mode <= next_capture_mode;
      compare_a_irq_enable <= next_compare_a_irq_enable;
      compare_a_flag <= next_compare_a_flag;
      flag_read_armed <= next_flag_read_armed;
      channel_run <= next_channel_run;
      channel_counter <= next_channel_counter;
      general_register_a <= next_general_register_a;
      div_cnt <= next_div_cnt;
      count_clk_prev <= next_count_clk_prev;
      cap_sync <= next_cap_sync;
      cap_level <= next_cap_level;
      tap_settle <= next_tap_settle;
      rd_data <= next_rd_data;
      compare_a_irq_request <= next_irq;
    end
  end

endmodule

`default_nettype wire

// ---- verif/tcc_channel_asserts.sv ----
`timescale 1ns/1ns
`default_nettype none
module tcc_channel_asserts
(
  // Watched ports.
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire tcc_pkg::tcc_bus_req_type bus_req,
  input wire logic [15:0] rd_data,
  input wire logic capture_in,
  input wire logic compare_a_irq_request
);
  import tcc_pkg::*;
  logic touched;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // Marks that register A may have left its reset value.
  always_ff @(posedge ref_clk or negedge reset_n)
    if (!reset_n)
      touched <= 1'b0;
    else if (bus_req.wr)
      touched <= 1'b1;
  rd_idle_a:
    assert property (!bus_req.rd |=> rd_data == 16'h0)
    else $error("read data not idle");
  unmapped_rd_a:
    assert property (bus_req.rd && bus_req.addr == 16'hf04e
      |=> rd_data == 16'h0) else $error("unmapped read not zero");
  gra_reset_a:
    assert property (bus_req.rd && bus_req.addr == TCC_ADDR_GRA && !touched
      |=> rd_data == TCC_GRA_RESET) else $error("register A not reset");
  gra_rw_a:
    assert property (bus_req.wr && bus_req.addr == TCC_ADDR_GRA ##1
      bus_req.rd && bus_req.addr == TCC_ADDR_GRA
      |=> rd_data == $past(bus_req.wdata, 2)) else $error("register A lost");
  ctrl_rsvd_a:
    assert property (bus_req.rd && bus_req.addr == TCC_ADDR_CONTROL
      |=> rd_data[15:7] == 9'h0) else $error("control spare bits set");
  irq_flag_a:
    assert property (bus_req.rd && bus_req.addr == TCC_ADDR_FLAGS &&
      compare_a_irq_request |=> rd_data == 16'h1) else $error("irq no flag");
  irq_off_a:
    assert property (bus_req.wr && bus_req.addr == TCC_ADDR_IRQ_ENABLE &&
      !bus_req.wdata[0] |-> ##2 !compare_a_irq_request)
    else $error("masked irq high");
  irq_hold_a:
    assert property (compare_a_irq_request && !bus_req.wr &&
      !$past(bus_req.wr) |=> compare_a_irq_request) else $error("irq lost");
  flag_w1_a:
    assert property (bus_req.wr && bus_req.addr == TCC_ADDR_FLAGS &&
      bus_req.wdata[0] && compare_a_irq_request |-> ##1
      compare_a_irq_request [*2]) else $error("write one cleared flag");
  // Main scenarios.
  cover property ($rose(compare_a_irq_request));
  cover property (bus_req.wr && bus_req.addr == TCC_ADDR_FLAGS);
  cover property ($rose(capture_in));
endmodule
`default_nettype wire

// ---- verif/tcc_channel_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module tcc_channel_tb;
  import tcc_pkg::*;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  tcc_bus_req_type bus_req = '0;
  logic capture_in = 1'b0;
  logic [15:0] rd_data;
  logic irq;
  int bad_count = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [15:0] d;
  time t0;
  logic [15:0] regs [6] = '{TCC_ADDR_START, TCC_ADDR_CONTROL, TCC_ADDR_MODE,
    TCC_ADDR_IRQ_ENABLE, TCC_ADDR_FLAGS, 16'hf04e};
  logic [15:0] cfg [4][3] = '{'{16'h26, 16'h3, 16'h100},
    '{16'h20, 16'h5, 16'h2}, '{16'h2b, 16'h4, 16'h40},
    '{16'h33, 16'h2, 16'h20}};
  // Channel under test.
  tcc_channel uut (.ref_clk(ref_clk), .reset_n(reset_n), .bus_req(bus_req),
    .rd_data(rd_data), .capture_in(capture_in),
    .compare_a_irq_request(irq));
  // Clock and hang guard.
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      final_report();
    end
  end
  // Compares a seen value with the expected one.
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    if (got !== exp)
      bad_count++;
  endtask
  // Cycles between two matches when a match clears the counter.
  function automatic logic [15:0] match_period(input logic [15:0] top,
    input logic [15:0] tick);
    return (top + 16'h1) * tick;
  endfunction
  // Drives one strobe cycle and leaves it for the next call.
  task automatic bus(input logic w, input logic r, input logic [15:0] a,
    input logic [15:0] v);
    @(posedge ref_clk);
    bus_req <= '{addr: a, wdata: v, wr: w, rd: r};
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] v);
    bus(1'b1, 1'b0, a, v);
    @(posedge ref_clk);
    bus_req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    bus(1'b0, 1'b1, a, 16'h0);
    @(posedge ref_clk);
    bus_req.rd <= 1'b0;
    #1 check(rd_data, exp);
  endtask
  // Waits a bounded time for the request and checks its level.
  task automatic wait_irq(input int limit, input logic exp);
    int n;
    n = 0;
    repeat (2) @(posedge ref_clk);
    #1;
    while (irq !== exp && n < limit)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    check({15'h0, irq}, {15'h0, exp});
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Runs the scenarios in order.
  initial
  begin
    void'($urandom(32'he6ccf458));
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rd(TCC_ADDR_GRA, TCC_GRA_RESET);
    foreach (regs[i]) rd(regs[i], 16'h0);
    repeat (8)
    begin
      d = 16'($urandom);
      bus(1'b1, 1'b0, TCC_ADDR_GRA, d);
      rd(TCC_ADDR_GRA, d);
      wr(TCC_ADDR_CONTROL, d);
      rd(TCC_ADDR_CONTROL, d & 16'h7f);
      wr(TCC_ADDR_MODE, d);
      rd(TCC_ADDR_MODE, d & 16'h3);
      wr(TCC_ADDR_COUNTER, d);
      repeat (20) @(posedge ref_clk);
      rd(TCC_ADDR_COUNTER, d);
    end
    wr(TCC_ADDR_CONTROL, 16'h0);
    wr(TCC_ADDR_GRA, 16'h0);
    wr(TCC_ADDR_COUNTER, 16'hfffe);
    wr(TCC_ADDR_IRQ_ENABLE, 16'h1);
    wr(TCC_ADDR_START, 16'h2);
    wait_irq(12, 1'b1);
    wr(TCC_ADDR_START, 16'h0);
    wr(TCC_ADDR_IRQ_ENABLE, 16'h0);
    wait_irq(0, 1'b0);
    wr(TCC_ADDR_IRQ_ENABLE, 16'h1);
    wr(TCC_ADDR_FLAGS, 16'h1);
    wr(TCC_ADDR_FLAGS, 16'h0);
    rd(TCC_ADDR_FLAGS, 16'h1);
    wr(TCC_ADDR_FLAGS, 16'h0);
    rd(TCC_ADDR_FLAGS, 16'h0);
    foreach (cfg[i])
    begin
      wr(TCC_ADDR_CONTROL, cfg[i][0]);
      wr(TCC_ADDR_GRA, cfg[i][1]);
      wr(TCC_ADDR_COUNTER, 16'h0);
      wr(TCC_ADDR_START, 16'h2);
      wait_irq(4000, 1'b1);
      t0 = $time;
      rd(TCC_ADDR_FLAGS, 16'h1);
      wr(TCC_ADDR_FLAGS, 16'h0);
      wait_irq(4000, 1'b1);
      d = match_period(cfg[i][1], cfg[i][2]);
      check(16'(($time - t0) / 10), d);
      wr(TCC_ADDR_START, 16'h0);
      rd(TCC_ADDR_FLAGS, 16'h1);
      wr(TCC_ADDR_FLAGS, 16'h0);
    end
    d = 16'($urandom);
    wr(TCC_ADDR_IO_CTRL, 16'h1);
    wr(TCC_ADDR_COUNTER, d);
    capture_in <= 1'b1;
    repeat (8) @(posedge ref_clk);
    capture_in <= 1'b0;
    rd(TCC_ADDR_GRA, d);
    rd(TCC_ADDR_FLAGS, 16'h1);
    final_report();
  end
endmodule
bind tcc_channel tcc_channel_asserts chk (.ref_clk(ref_clk),
  .reset_n(reset_n), .bus_req(bus_req), .rd_data(rd_data),
  .capture_in(capture_in), .compare_a_irq_request(compare_a_irq_request));
`default_nettype wire
